// >>> design/asb_pkg.sv
// Constants, layouts and helpers for the sequence-B trigger front end
// Notes on behaviour
// - Twelve-bit mask; bit n includes channel n
// - Launch converts enabled channels, lowest first
// - Software changes mask only while disabled
// - Three-bit trigger input select, resets zero
// - Change trigger and polarity only while disabled
// - Polarity 0 falling edge, 1 rising edge
// - Bypass bit skips the trigger synchronizer stages
// - Synchronous mode: pulse lasts one system clock
// - Bypass only for triggers synchronous to clock
// - Asynchronous mode bypass needs one converter cycle
// - Channel mask resets to all zeros
// - Start bit launches one pass, reads zero
// - Continuous bit repeats passes, ignores triggers
// - Single step converts next channel per trigger
package asb_pkg;

  // Register map, byte addresses on APB
  localparam logic [31:0] ASB_CTRL_ADDR = 32'h4001_c00c;
  localparam logic [31:0] ASB_STAT_ADDR = 32'h4001_c0fc;

  // Control register field positions
  localparam int ASB_CHAN_LSB = 0;
  localparam int ASB_CHAN_W = 12;
  localparam int ASB_TSEL_LSB = 12;
  localparam int ASB_TSEL_W = 3;
  localparam int ASB_POL_BIT = 18;
  localparam int ASB_SKIP_BIT = 19;
  localparam int ASB_START_BIT = 26;
  localparam int ASB_BURST_BIT = 27;
  localparam int ASB_STEP_BIT = 28;
  localparam int ASB_MODE_BIT = 30;
  localparam int ASB_ON_BIT = 31;

  // Status register field positions
  localparam int ASB_ST_BUSY_BIT = 0;
  localparam int ASB_ST_CHAN_LSB = 4;
  localparam int ASB_ST_PTR_LSB = 8;

  // Reset values
  localparam logic [11:0] ASB_CHAN_RST = 12'h000;
  localparam logic [2:0] ASB_TSEL_RST = 3'h0;
  localparam logic ASB_POL_RST = 1'b0;
  localparam logic ASB_SKIP_RST = 1'b0;

  // Trigger source count and pulse timing
  localparam int ASB_NUM_TRIG = 8;
  localparam int ASB_CLK_PERIOD_NS = 40;
  localparam int ASB_TRIG_MIN_NS = 40;
  localparam int ASB_TRIG_MIN_CYC =
    (ASB_TRIG_MIN_NS + ASB_CLK_PERIOD_NS - 1) / ASB_CLK_PERIOD_NS;

  // Lowest enabled channel at or above from; bit 4 flags a hit
  function automatic logic [4:0] asb_next_chan(
    input logic [11:0] mask,
    input logic [4:0] from
  );
    logic [4:0] r;
    r = 5'h00;
    for (int i = 11; i >= 0; i--) begin
      if (mask[i] && (5'(i) >= from)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : asb_next_chan

endpackage : asb_pkg

// >>> design/asb_trig_if.sv
// Hardware trigger lines between trigger sources and the sequencer
`timescale 1ns/1ps
interface asb_trig_if;
  logic [asb_pkg::ASB_NUM_TRIG-1:0] trig;
  modport dev (input trig);
  modport src (output trig);
endinterface : asb_trig_if

// >>> design/asb_seq_dev.sv
// Sequence-B control register, trigger edge detect and channel sequencer
`timescale 1ns/1ps
module asb_seq_dev (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  asb_trig_if.dev tif,
  output logic conv_req,
  output logic [3:0] conv_chan,
  input wire logic conv_done,
  output logic pass_done
);

  typedef enum logic [0:0] {
    ASB_IDLE,
    ASB_CONV
  } asb_state_t;

  typedef struct packed {
    logic [asb_pkg::ASB_NUM_TRIG-1:0] sync1;
    logic [asb_pkg::ASB_NUM_TRIG-1:0] sync2;
    logic prev_lvl;
    logic [11:0] chan_mask;
    logic [2:0] trig_sel;
    logic pol;
    logic skip;
    logic burst;
    logic step;
    logic mode;
    logic on;
    logic ack;
    logic [31:0] rdata;
    asb_state_t state;
    logic [4:0] ptr;
    logic [3:0] chan;
    logic req;
    logic done;
    logic go;
  } asb_dev_st_t;

  asb_dev_st_t st_r;
  asb_dev_st_t st_nxt;

  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl;
  logic start_wr;
  logic lvl;
  logic edge_seen;
  logic launch;
  logic [4:0] first_hit;
  logic [4:0] step_hit;
  logic [4:0] after_hit;
  logic [31:0] ctrl_view;
  logic [31:0] stat_view;

  // Bus decode; the slave inserts one wait state so read data is registered
  assign access = psel && penable;
  assign hit_ctrl = (paddr == asb_pkg::ASB_CTRL_ADDR);
  assign hit_stat = (paddr == asb_pkg::ASB_STAT_ADDR);
  assign pready = access && st_r.ack;
  assign pslverr = pready && !(hit_ctrl || hit_stat);
  assign wr_ctrl = pready && pwrite && hit_ctrl && pce;
  // Start strobe, held one cycle so it acts on the word just written
  assign start_wr = wr_ctrl && pwdata[asb_pkg::ASB_START_BIT];

  // Register views; reserved and start bits read zero
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[asb_pkg::ASB_CHAN_LSB +: asb_pkg::ASB_CHAN_W] = st_r.chan_mask;
    ctrl_view[asb_pkg::ASB_TSEL_LSB +: asb_pkg::ASB_TSEL_W] = st_r.trig_sel;
    ctrl_view[asb_pkg::ASB_POL_BIT] = st_r.pol;
    ctrl_view[asb_pkg::ASB_SKIP_BIT] = st_r.skip;
    ctrl_view[asb_pkg::ASB_BURST_BIT] = st_r.burst;
    ctrl_view[asb_pkg::ASB_STEP_BIT] = st_r.step;
    ctrl_view[asb_pkg::ASB_MODE_BIT] = st_r.mode;
    ctrl_view[asb_pkg::ASB_ON_BIT] = st_r.on;
    stat_view = 32'h0000_0000;
    stat_view[asb_pkg::ASB_ST_BUSY_BIT] = (st_r.state == ASB_CONV);
    stat_view[asb_pkg::ASB_ST_CHAN_LSB +: 4] = st_r.chan;
    stat_view[asb_pkg::ASB_ST_PTR_LSB +: 5] = st_r.ptr;
  end

  // Selected trigger level; bypass trades metastability for latency
  assign lvl = st_r.skip ? tif.trig[st_r.trig_sel] :
    st_r.sync2[st_r.trig_sel];

  // Edge against last cycle's level, in the chosen direction
  assign edge_seen = st_r.pol ? (lvl && !st_r.prev_lvl) :
    (!lvl && st_r.prev_lvl);

  // Triggers count only while on; continuous mode ignores them
  assign launch = st_r.on &&
    ((edge_seen && !st_r.burst) || st_r.go || st_r.burst);

  // Channel search: full pass from 0, step from the pointer
  assign first_hit = asb_pkg::asb_next_chan(st_r.chan_mask, 5'h00);
  assign step_hit = asb_pkg::asb_next_chan(st_r.chan_mask, st_r.ptr);
  assign after_hit = asb_pkg::asb_next_chan(st_r.chan_mask,
    {1'b0, st_r.chan} + 5'h01);

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.req = 1'b0;
    st_nxt.done = 1'b0;
    // One-cycle start pulse; dropped if the sequencer is busy
    st_nxt.go = start_wr;

    // Two-stage synchronizer on every trigger line
    st_nxt.sync1 = tif.trig;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev_lvl = lvl;

    // Wait-state flag and registered read data
    st_nxt.ack = access && !st_r.ack;
    if (access && !st_r.ack) begin
      st_nxt.rdata = hit_ctrl ? ctrl_view :
        (hit_stat ? stat_view : 32'h0000_0000);
    end

    // Control write; mask stored as written, software keeps it stable
    if (wr_ctrl) begin
      st_nxt.chan_mask = pwdata[asb_pkg::ASB_CHAN_LSB +:
        asb_pkg::ASB_CHAN_W];
      st_nxt.trig_sel = pwdata[asb_pkg::ASB_TSEL_LSB +:
        asb_pkg::ASB_TSEL_W];
      st_nxt.pol = pwdata[asb_pkg::ASB_POL_BIT];
      st_nxt.skip = pwdata[asb_pkg::ASB_SKIP_BIT];
      st_nxt.burst = pwdata[asb_pkg::ASB_BURST_BIT];
      st_nxt.step = pwdata[asb_pkg::ASB_STEP_BIT];
      st_nxt.mode = pwdata[asb_pkg::ASB_MODE_BIT];
      st_nxt.on = pwdata[asb_pkg::ASB_ON_BIT];
    end

    // Sequencer
    unique case (st_r.state)
      ASB_IDLE: begin
        if (launch) begin
          if (st_r.step && !st_r.burst) begin
            // One channel per launch, wrapping after the last
            if (step_hit[4]) begin
              st_nxt.chan = step_hit[3:0];
              st_nxt.state = ASB_CONV;
              st_nxt.req = 1'b1;
            end else if (first_hit[4]) begin
              st_nxt.chan = first_hit[3:0];
              st_nxt.state = ASB_CONV;
              st_nxt.req = 1'b1;
            end
          end else if (first_hit[4]) begin
            // Whole pass begins at the lowest enabled channel
            st_nxt.chan = first_hit[3:0];
            st_nxt.state = ASB_CONV;
            st_nxt.req = 1'b1;
          end
        end
      end
      ASB_CONV: begin
        if (conv_done) begin
          if (st_r.step && !st_r.burst) begin
            // Remember where the next step resumes
            st_nxt.ptr = after_hit[4] ? {1'b0, after_hit[3:0]} : 5'h00;
            st_nxt.state = ASB_IDLE;
            st_nxt.done = !after_hit[4];
          end else if (after_hit[4] && st_r.on) begin
            // Disable halts at the end of the current conversion
            st_nxt.chan = after_hit[3:0];
            st_nxt.req = 1'b1;
          end else begin
            // Pass ends; idle relaunches while continuous is set
            st_nxt.ptr = 5'h00;
            st_nxt.state = ASB_IDLE;
            st_nxt.done = !after_hit[4];
          end
        end
      end
    endcase
  end

  // State register; the clock enable freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.sync1 <= '0;
      st_r.sync2 <= '0;
      st_r.prev_lvl <= 1'b0;
      st_r.chan_mask <= asb_pkg::ASB_CHAN_RST;
      st_r.trig_sel <= asb_pkg::ASB_TSEL_RST;
      st_r.pol <= asb_pkg::ASB_POL_RST;
      st_r.skip <= asb_pkg::ASB_SKIP_RST;
      st_r.burst <= 1'b0;
      st_r.step <= 1'b0;
      st_r.mode <= 1'b0;
      st_r.on <= 1'b0;
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
      st_r.state <= ASB_IDLE;
      st_r.ptr <= 5'h00;
      st_r.chan <= 4'h0;
      st_r.req <= 1'b0;
      st_r.done <= 1'b0;
      st_r.go <= 1'b0;
    end else if (pce) begin
      st_r <= st_nxt;
    end
  end

  // Outputs from flip-flops
  assign prdata = st_r.rdata;
  assign conv_req = st_r.req;
  assign conv_chan = st_r.chan;
  assign pass_done = st_r.done;

endmodule : asb_seq_dev

// >>> design/asb_trig_src.sv
// Trigger source end: drives timed pulses onto the trigger lines
`timescale 1ns/1ps
module asb_trig_src #(
  parameter int PULSE_CYC = asb_pkg::ASB_TRIG_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic [asb_pkg::ASB_NUM_TRIG-1:0] idle_lvl,
  input wire logic fire,
  input wire logic [2:0] fire_sel,
  output logic busy,
  asb_trig_if.src tif
);

  typedef struct packed {
    logic [asb_pkg::ASB_NUM_TRIG-1:0] act;
    logic [15:0] cnt;
  } asb_src_st_t;

  asb_src_st_t st_r;
  asb_src_st_t st_nxt;

  // Pulse length never under one clock period
  localparam logic [15:0] LEN = 16'((PULSE_CYC < 1) ? 1 : PULSE_CYC);

  // Accept a fire only when no pulse is in flight
  always_comb begin
    st_nxt = st_r;
    if (st_r.cnt != 16'h0000) begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
      if (st_r.cnt == 16'h0001) begin
        st_nxt.act = '0;
      end
    end else if (fire) begin
      st_nxt.act = '0;
      st_nxt.act[fire_sel] = 1'b1;
      st_nxt.cnt = LEN;
    end
  end

  // Clocked by the system clock, so the sink may skip sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.act <= '0;
      st_r.cnt <= 16'h0000;
    end else if (pce) begin
      st_r <= st_nxt;
    end
  end

  // Pulse is the inverse of each line's idle level
  assign tif.trig = idle_lvl ^ st_r.act;
  assign busy = (st_r.cnt != 16'h0000);

endmodule : asb_trig_src

// >>> tb/asb_seq_sva.sv
// Checker for the sequence-B APB port, trigger lines and converter handshake
`timescale 1ns/1ps
module asb_seq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] trig,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_req,
  input wire logic [3:0] conv_chan,
  input wire logic conv_done,
  input wire logic pass_done
);
  logic [31:0] shadow_r;
  logic acc;
  logic is_ctrl;
  assign acc = psel & penable & pready;
  assign is_ctrl = paddr == asb_pkg::ASB_CTRL_ADDR;
  // Shadow of stored fields; start and reserved bits never read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shadow_r <= 32'h0000_0000;
    else if (acc && pwrite && is_ctrl) shadow_r <= pwdata & 32'hd80c_7fff;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  property p_ctrl_rd; acc && !pwrite && is_ctrl |-> prdata == shadow_r;
  endproperty
  property p_unmapped;
    acc && !is_ctrl && paddr != asb_pkg::ASB_STAT_ADDR |-> pslverr && !prdata;
  endproperty
  property p_req_pulse; conv_req |=> !conv_req; endproperty
  property p_chan_hold; !conv_req |-> $stable(conv_chan); endproperty
  property p_pass; pass_done |-> $past(conv_done); endproperty
  property p_req_on; conv_req |-> shadow_r[31]; endproperty
  property p_trig_hold; $changed(trig) |=> $stable(trig); endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("bad readback");
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  a_req_pulse: assert property (p_req_pulse) else $error("long req");
  a_chan_hold: assert property (p_chan_hold) else $error("chan moved");
  a_pass: assert property (p_pass) else $error("early pass end");
  a_req_on: assert property (p_req_on) else $error("req while off");
  a_trig_hold: assert property (p_trig_hold) else $error("short pulse");
endmodule : asb_seq_sva

// >>> tb/adc_seq_b_trigger_setup_tb.sv
// Bench joining sequencer and trigger source, driven over APB
`timescale 1ns/1ps
module adc_seq_b_trigger_setup_tb;
  localparam logic [31:0] ca = asb_pkg::ASB_CTRL_ADDR;
  logic pclk, presetn, psel, penable, pwrite, fire, conv_done, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pready, pslverr, conv_req, pass_done, busy;
  logic [3:0] conv_chan;
  logic [7:0] idle_lvl, trig_q;
  logic [2:0] fire_sel;
  logic [3:0] got[$];
  int errors = 0, n_tests = 0, cyc = 0, t0 = -1, lat = -1, pass_n = 0, mark;
  asb_trig_if tif_i();
  asb_seq_dev asb_seq_dev_i(.pclk, .presetn, .pce(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tif(tif_i.dev),
    .conv_req, .conv_chan, .conv_done, .pass_done);
  // Source on pclk, pulses of three cycles
  asb_trig_src #(.PULSE_CYC(3)) asb_trig_src_i(.pclk, .presetn, .pce(1'b1),
    .idle_lvl, .fire, .fire_sel, .busy, .tif(tif_i.src));
  asb_seq_sva asb_seq_sva_i(.pclk, .presetn, .trig(tif_i.trig), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .conv_req, .conv_chan, .conv_done, .pass_done);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Converter stand-in answers each request next cycle; logs latency
  always @(posedge pclk) begin
    cyc++;
    if (trig_q !== tif_i.trig && t0 < 0) t0 = cyc;
    trig_q = tif_i.trig;
    if (conv_req === 1'b1) got.push_back(conv_chan);
    if (conv_req === 1'b1 && lat < 0) lat = cyc - t0;
    if (pass_done === 1'b1) pass_n++;
    conv_done <= conv_req;
  end
  function automatic logic [31:0] cw(input logic [11:0] m,
    input logic [2:0] s, input logic p, k, st, bu, sp, on);
    return {on, 2'h0, sp, bu, st, 6'h00, k, p, 3'h0, s, m};
  endfunction : cw
  task automatic chk(input logic [31:0] g, e, input string w);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask : chk
  // One transfer; an idle cycle after it keeps drives one per step
  task automatic apb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) chk(0, 1, "apb hang");
  endtask : apb
  task automatic arm();
    mark = pass_n;
    got.delete();
    t0 = -1;
    lat = -1;
  endtask : arm
  task automatic shoot(input logic [2:0] k);
    while (busy !== 1'b0) @(posedge pclk);
    fire <= 1'b1;
    fire_sel <= k;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : shoot
  // Waits for the pass end, then checks channel order lowest first
  task automatic pass_wait(input logic [11:0] m);
    int n;
    n = 0;
    while (pass_n == mark && n < 200) begin
      @(posedge pclk);
      n++;
    end
    for (int c = 0; c < 12; c++) begin
      if (m[c]) chk(got.size() ? got.pop_front() : 4'hx, c, "chan");
    end
    chk(got.size(), 0, "extra conv");
  endtask : pass_wait
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #1_000_000;
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, fire, conv_done} = 6'h00;
    {paddr, pwdata, idle_lvl, fire_sel} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, ca, 0); chk(rd, 0, "ctrl reset");
    apb(1'b0, asb_pkg::ASB_STAT_ADDR, 0);
    chk(rd, 0, "stat reset");
    apb(1'b0, 32'h4001_c010, 0);
    chk(rd, 0, "unmapped data");
    chk({31'h0, err}, 1, "unmapped err");
    $display("test reset done");
    arm();
    apb(1'b1, ca, cw(12'h0a4, 0, 0, 0, 1, 0, 0, 1) | 32'h0003_8000);
    pass_wait(12'h0a4);
    apb(1'b0, ca, 0); chk(rd, cw(12'h0a4, 0, 0, 0, 0, 0, 0, 1), "rb");
    $display("test software start done");
    // Every input line, both edges, with and without the synchronizer
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, ca, 0);
        // Odd lines launch on the trailing edge, three cycles later
        idle_lvl <= {8{~(p[0] ^ k[0])}};
        apb(1'b1, ca, cw(12'h801, k[2:0], p[0], p[1], 0, 0, 0, 1));
        arm();
        shoot(k[2:0]);
        pass_wait(12'h801);
        chk(lat, (p[1] ? 1 : 3) + 3 * k[0], "latency");
        chk(lat - 3 * k[0], p[1] ? 1 : 3, "sync path");
        arm();
        shoot(3'(k + 1));
        repeat (12) @(posedge pclk);
        chk(got.size(), 0, "other line");
      end
    end
    $display("test hardware triggers done");
    apb(1'b1, ca, cw(12'h001, 0, 1, 1, 0, 0, 0, 0));
    arm();
    shoot(3'h0);
    repeat (12) @(posedge pclk);
    chk(got.size(), 0, "disabled");
    for (int i = 0; i < 3; i++) begin
      arm();
      apb(1'b1, ca, cw(12'h006, 0, 1, 1, 1, 0, 1, 1));
      repeat (12) @(posedge pclk);
      chk(got.size() ? got[0] : 4'hx, i == 1 ? 2 : 1, "step");
      chk(pass_n - mark, i == 1, "step end");
    end
    $display("test single step done");
    arm();
    apb(1'b1, ca, cw(12'h008, 0, 1, 1, 0, 1, 0, 1));
    repeat (40) @(posedge pclk);
    chk(got.size() >= 3, 1, "burst");
    apb(1'b1, ca, cw(12'h008, 0, 1, 1, 0, 0, 0, 1));
    repeat (12) @(posedge pclk);
    arm();
    repeat (20) @(posedge pclk);
    chk(got.size(), 0, "burst stop");
    $display("test burst done");
    print_verdict();
  end
endmodule : adc_seq_b_trigger_setup_tb
